// ===== hw/ast_pkg.sv
/*
  Constants and types of the sequencer status and interval timer.
  Assumes a 40 MHz system clock and a byte-addressed register bus.
*/
package ast_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_INTERVAL = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h1C;

  // Bit positions in the flags word.
  localparam int FLAG_READY = 0;
  localparam int FLAG_OVERFLOW = 1;
  localparam int FLAG_TIMER = 2;
  localparam int FLAG_IRAM = 3;
  localparam int FLAG_PENDING = 4;

  // Reset values.
  localparam logic [15:0] INTERVAL_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [2:0] CONTROL_RST = 3'h0;

  // Tick of the interval timer, in microseconds, and the clock rate.
  localparam int TICK_US = 100;
  localparam int CLK_MHZ = 40;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  // Sticky flags, bit 3 down to bit 0.
  typedef struct packed {
    logic iram_error;
    logic timer_error;
    logic overflow;
    logic results_ready;
  } ast_flags_t;

  // Control word, bit 2 down to bit 0.
  typedef struct packed {
    logic sequencer_irq_enable;
    logic trigger_select;
    logic sequencer_run;
  } ast_control_t;

  // Sequencer run state.
  typedef enum logic [2:0] {
    ST_STOP = 3'h1,
    ST_WAIT = 3'h2,
    ST_BUSY = 3'h4
  } ast_state_t;
endpackage : ast_pkg

// ===== hw/ast_status_timer.sv
/*
  Status flags, interval timer and start control of a conversion
  sequencer, with an Avalon-MM slave for its registers.
  Assumes the sequence engine pulses seq_done_in once per finished
  sequence and that all inputs are synchronous to sys_clk_in.
*/
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Flags word bits 31 to 5 ignore writes and read zero.
// - Bit 4 reads one while an interrupt is pending, drops when flags clear.
// - Starting with empty instruction memory sets the empty-instruction flag.
// - Flags 0 to 3 are sticky; writing one clears, zero leaves them.
// - Timer expiry during a running sequence sets the timer error.
// - With interval zero the timer error is never set and reads zero.
// - Sequence end with results still unread sets the overflow flag.
// - With interval zero the overflow flag is never set and reads zero.
// - Each finished sequence with fresh results sets results ready.
// - In continuous mode results ready is set but raises no interrupt.
// - Timer and external modes: all flags interrupt; continuous: only empty.
// - Interval register holds 16-bit preload, reset zero, upper bits zero.
// - Preload counts the interval in 100 us steps up to 6.5535 s.
// - The interval timer takes its time base from the 40 MHz clock.
// - On reaching the preload the sequencer starts a new sequence.
// - With preload zero a new sequence starts right after the last ends.
// - An error flag stops the sequencer after its last instruction.
// - Interrupt needs sequencer enable, master enable and a qualifying flag.
// - Control bit 1 picks the trigger: timer or external line.
module ast_status_timer (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Sequence engine and trigger line.
  input wire logic seq_done_in,
  input wire logic instr_empty_in,
  input wire logic ext_trigger_in,
  output logic seq_start_out,
  output logic sequencer_irq_out
);

  // Matches a bus address against a register offset.
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  logic ack, next_ack, wr_go, trig_prev;
  logic [31:0] rdata, next_rdata;
  ast_pkg::ast_flags_t flags, next_flags, set_v, clr_v;
  ast_pkg::ast_control_t ctrl, next_ctrl;
  ast_pkg::ast_state_t state, next_state;
  logic master_irq_enable, next_mie;
  logic [15:0] interval, next_interval;
  logic start_q, next_start;
  logic irq_q, next_irq;
  logic [11:0] pre, next_pre;
  logic [15:0] ticks, next_ticks;
  logic cont, running, timer_hit, ext_rise, trig, start_req, pending;
  logic [4:0] flags_rd;

  // Mode decode, qualified pending bit and the visible flags word.
  assign cont = (interval == 16'h0000);
  assign ext_rise = ext_trigger_in & ~trig_prev;
  assign trig = ctrl.trigger_select ? ext_rise : timer_hit;
  assign pending = cont ? flags.iram_error : (|flags);
  assign flags_rd = {pending, flags.iram_error,
                     flags.timer_error & ~cont,
                     flags.overflow & ~cont,
                     flags.results_ready};
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign avs_readdata_out = rdata;
  assign seq_start_out = start_q;
  assign sequencer_irq_out = irq_q;
  assign wr_go = avs_write_in & ack;

  // Bus slave: one wait cycle, then read data stands for the taking edge.
  always_comb
  begin
    next_ack = (avs_read_in | avs_write_in) & ~ack;
    next_rdata = rdata;
    if (avs_read_in && !ack)
    begin
      if (hit(avs_address_in, ast_pkg::ADDR_CONTROL))
        next_rdata = {29'h0, ctrl};
      else if (hit(avs_address_in, ast_pkg::ADDR_FLAGS))
        next_rdata = {27'h0, flags_rd};
      else if (hit(avs_address_in, ast_pkg::ADDR_INTERVAL))
        next_rdata = {16'h0, interval};
      else if (hit(avs_address_in, ast_pkg::ADDR_IRQ_CTRL))
        next_rdata = {31'h0, master_irq_enable};
      else
        next_rdata = 32'h0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      ack <= 1'b0;
      rdata <= 32'h0;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Interval timer: 100 us ticks counted against the preload.
  assign running = (state != ast_pkg::ST_STOP) && !ctrl.trigger_select
                   && !cont;
  assign timer_hit = running && (pre == ast_pkg::TICK_LAST)
                     && (16'(ticks + 16'h0001) == interval);

  always_comb
  begin
    next_pre = pre;
    next_ticks = ticks;
    if (!running)
    begin
      next_pre = 12'h000;
      next_ticks = 16'h0000;
    end
    else if (pre == ast_pkg::TICK_LAST)
    begin
      next_pre = 12'h000;
      next_ticks = timer_hit ? 16'h0000 : 16'(ticks + 16'h0001);
    end
    else
      next_pre = 12'(pre + 12'h001);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      pre <= 12'h000;
      ticks <= 16'h0000;
    end
    else
    begin
      pre <= next_pre;
      ticks <= next_ticks;
    end
  end

  // Registers, sticky flags and the start and stop sequencing.
  always_comb
  begin
    next_ctrl = ctrl;
    next_mie = master_irq_enable;
    next_interval = interval;
    next_state = state;
    next_start = 1'b0;
    set_v = '0;
    clr_v = '0;
    start_req = 1'b0;
    if (wr_go && avs_byteenable_in[0])
    begin
      if (hit(avs_address_in, ast_pkg::ADDR_CONTROL))
        next_ctrl = avs_writedata_in[2:0];
      else if (hit(avs_address_in, ast_pkg::ADDR_FLAGS))
        clr_v = avs_writedata_in[3:0];
      else if (hit(avs_address_in, ast_pkg::ADDR_IRQ_CTRL))
        next_mie = avs_writedata_in[0];
    end
    if (wr_go && hit(avs_address_in, ast_pkg::ADDR_INTERVAL))
    begin
      if (avs_byteenable_in[0])
        next_interval[7:0] = avs_writedata_in[7:0];
      if (avs_byteenable_in[1])
        next_interval[15:8] = avs_writedata_in[15:8];
    end
    case (state)
      ast_pkg::ST_STOP:
      begin
        if (next_ctrl.sequencer_run)
          start_req = 1'b1;
      end
      ast_pkg::ST_WAIT:
      begin
        if (!next_ctrl.sequencer_run)
          next_state = ast_pkg::ST_STOP;
        else if (trig)
          start_req = 1'b1;
      end
      ast_pkg::ST_BUSY:
      begin
        if (timer_hit)
          set_v.timer_error = 1'b1;
        if (cont && !next_ctrl.sequencer_run)
          next_state = ast_pkg::ST_STOP;
        else if (seq_done_in)
        begin
          set_v.results_ready = 1'b1;
          if (flags.results_ready && !cont)
            set_v.overflow = 1'b1;
          if (flags.overflow || flags.timer_error || flags.iram_error
              || set_v.overflow || set_v.timer_error
              || !next_ctrl.sequencer_run)
          begin
            next_state = ast_pkg::ST_STOP;
            next_ctrl.sequencer_run = 1'b0;
          end
          else if (cont)
            start_req = 1'b1;
          else
            next_state = ast_pkg::ST_WAIT;
        end
      end
      default:
        next_state = ast_pkg::ST_STOP;
    endcase
    if (start_req)
    begin
      if (instr_empty_in)
      begin
        set_v.iram_error = 1'b1;
        next_ctrl.sequencer_run = 1'b0;
        next_state = ast_pkg::ST_STOP;
      end
      else
      begin
        next_start = 1'b1;
        next_state = ast_pkg::ST_BUSY;
      end
    end
    // A flag set in the clearing cycle survives the clear.
    next_flags = (flags & ~clr_v) | set_v;
    next_irq = pending & ctrl.sequencer_irq_enable & master_irq_enable;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      flags <= ast_pkg::FLAGS_RST;
      ctrl <= ast_pkg::CONTROL_RST;
      master_irq_enable <= 1'b0;
      interval <= ast_pkg::INTERVAL_RST;
      state <= ast_pkg::ST_STOP;
      start_q <= 1'b0;
      irq_q <= 1'b0;
      trig_prev <= 1'b0;
    end
    else
    begin
      flags <= next_flags;
      ctrl <= next_ctrl;
      master_irq_enable <= next_mie;
      interval <= next_interval;
      state <= next_state;
      start_q <= next_start;
      irq_q <= next_irq;
      trig_prev <= ext_trigger_in;
    end
  end

  // Checks on the flags, the timer and the interrupt path.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  reserved_zero_a: assert property (
    avs_read_in && !ack && hit(avs_address_in, ast_pkg::ADDR_FLAGS)
    |=> avs_readdata_out[31:5] == 27'h0)
    else $error("Reserved flag bits read nonzero.");

  pending_bit_a: assert property (
    flags_rd[4] == (cont ? flags.iram_error
                         : (flags != ast_pkg::FLAGS_RST)))
    else $error("Pending bit disagrees with qualified flags.");

  empty_start_a: assert property (
    start_req && instr_empty_in
    |=> flags.iram_error && !seq_start_out && state == ast_pkg::ST_STOP)
    else $error("Empty instruction start not flagged.");

  flag_clear_a: assert property (
    wr_go && avs_byteenable_in[0] && avs_writedata_in[0]
    && hit(avs_address_in, ast_pkg::ADDR_FLAGS) && !set_v.results_ready
    |=> !flags.results_ready)
    else $error("Write of one did not clear results ready.");

  timer_error_a: assert property (
    timer_hit && state == ast_pkg::ST_BUSY |=> flags.timer_error)
    else $error("Timer expiry in a sequence not flagged.");

  cont_mask_a: assert property (
    cont |-> !set_v.timer_error && !set_v.overflow && flags_rd[2:1] == 2'b00)
    else $error("Continuous mode shows timer or overflow flag.");

  overflow_a: assert property (
    state == ast_pkg::ST_BUSY && seq_done_in && flags.results_ready
    && !cont |=> flags.overflow)
    else $error("Unread results did not raise overflow.");

  ready_set_a: assert property (
    state == ast_pkg::ST_BUSY && seq_done_in
    && !(cont && !next_ctrl.sequencer_run) |=> flags.results_ready)
    else $error("Finished sequence did not set results ready.");

  irq_gate_a: assert property (
    sequencer_irq_out |-> $past(ctrl.sequencer_irq_enable && master_irq_enable
                                && pending))
    else $error("Interrupt raised without its enables.");

  timer_start_a: assert property (
    timer_hit && state == ast_pkg::ST_WAIT && next_ctrl.sequencer_run
    && !instr_empty_in |=> seq_start_out ##1 !seq_start_out)
    else $error("Timer expiry did not start one sequence.");

  error_stop_a: assert property (
    state == ast_pkg::ST_BUSY && seq_done_in && !cont && flags.timer_error
    |=> !ctrl.sequencer_run && state == ast_pkg::ST_STOP)
    else $error("Sequencer kept running after an error.");

  wait_answer_a: assert property (
    (avs_read_in || avs_write_in) && !ack |=> !avs_waitrequest_out)
    else $error("Bus answer later than one wait cycle.");

  timer_run_c: cover property (state == ast_pkg::ST_WAIT && timer_hit
                               ##1 seq_start_out);
  overflow_c: cover property (flags.overflow && sequencer_irq_out);
  cont_loop_c: cover property (cont && seq_done_in ##1 seq_start_out);
endmodule : ast_status_timer

// ===== testbench/ast_status_timer_bench.sv
/*
  Self-checking bench of the sequencer status flags and interval timer.
  Assumes the fixed 4000-cycle tick and a bus answer within 20 cycles.
*/
`timescale 1ns/1ps
module ast_status_timer_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic done = 1'b0;
  logic empty = 1'b0;
  logic ext = 1'b0;
  logic [31:0] rdata;
  logic wreq;
  logic start;
  logic irq;
  logic [31:0] v;
  int errors = 0;
  int n_checks = 0;
  int since = 0;
  int gap = 0;
  int nst = 0;

  ast_status_timer uut (
    .sys_clk_in(clk), .srst_in(srst), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .seq_done_in(done),
    .instr_empty_in(empty), .ext_trigger_in(ext),
    .seq_start_out(start), .sequencer_irq_out(irq));

  // The 40 MHz clock.
  initial forever #12.5 clk = ~clk;

  // Counts starts and the cycles between them, sampled mid-cycle.
  always @(negedge clk)
  begin
    if (start === 1'b1)
    begin
      gap <= since + 1;
      since <= 0;
      nst <= nst + 1;
    end
    else
      since <= since + 1;
  end

  // Ends the run with the verdict.
  task automatic conclude();
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wreq !== 1'b0 && k < 20);
    if (k >= 20)
    begin
      errors++;
      conclude();
    end
    // Read data is taken at the edge that sees waitrequest low.
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Reads a register and compares it.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, v);
  endtask : rdc

  // One-cycle pulse of the sequence end.
  task automatic pulse_done();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask : pulse_done

  // Waits, bounded, for the next start pulse.
  task automatic wait_st();
    int n0;
    int k;
    n0 = nst;
    k = 0;
    while (nst == n0 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000)
    begin
      errors++;
      conclude();
    end
  endtask : wait_st

  // Reset values, reserved bits and an unmapped address.
  task automatic t_regs();
    rdc(ast_pkg::ADDR_FLAGS, 32'h0, "flags reset");
    rdc(ast_pkg::ADDR_INTERVAL, 32'h0, "interval reset");
    bus(1'b1, ast_pkg::ADDR_INTERVAL, 32'hFFFFFFFF);
    rdc(ast_pkg::ADDR_INTERVAL, 32'h0000FFFF, "interval");
    bus(1'b1, ast_pkg::ADDR_INTERVAL, 32'h0);
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
    rdc(ast_pkg::ADDR_FLAGS, 32'h0, "flags reserved");
    rdc(8'h04, 32'h0, "unmapped");
  endtask : t_regs

  // Start with empty instruction memory, masking and clearing.
  task automatic t_iram();
    @(posedge clk);
    empty <= 1'b1;
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h5);
    rdc(ast_pkg::ADDR_FLAGS, 32'h18, "iram flag");
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, ast_pkg::ADDR_IRQ_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'h0);
    rdc(ast_pkg::ADDR_FLAGS, 32'h18, "write zero");
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'h8);
    rdc(ast_pkg::ADDR_FLAGS, 32'h0, "iram clear");
    chk("irq off", 32'h0, {31'h0, irq});
    rdc(ast_pkg::ADDR_CONTROL, 32'h4, "run off");
    @(posedge clk);
    empty <= 1'b0;
  endtask : t_iram

  // Continuous mode: back-to-back sequences, no overflow, no irq.
  task automatic t_cont();
    int n0;
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h5);
    wait_st();
    n0 = nst;
    pulse_done();
    repeat (2) @(negedge clk);
    chk("restart", n0 + 1, nst);
    pulse_done();
    rdc(ast_pkg::ADDR_FLAGS, 32'h1, "cont flags");
    chk("cont irq", 32'h0, {31'h0, irq});
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h4);
    n0 = nst;
    repeat (20) @(negedge clk);
    chk("cont stop", n0, nst);
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'hF);
  endtask : t_cont

  // Timer mode: period, overflow, stop, timer error, masking.
  task automatic t_timer();
    int n0;
    bus(1'b1, ast_pkg::ADDR_INTERVAL, 32'h1);
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h5);
    wait_st();
    pulse_done();
    rdc(ast_pkg::ADDR_FLAGS, 32'h11, "ready");
    wait_st();
    chk("period", 32'd4000, gap);
    pulse_done();
    rdc(ast_pkg::ADDR_FLAGS, 32'h13, "overflow");
    n0 = nst;
    repeat (4100) @(negedge clk);
    chk("halt", n0, nst);
    rdc(ast_pkg::ADDR_CONTROL, 32'h4, "run cleared");
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'hF);
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h5);
    wait_st();
    repeat (4010) @(negedge clk);
    rdc(ast_pkg::ADDR_FLAGS, 32'h14, "timer error");
    pulse_done();
    rdc(ast_pkg::ADDR_FLAGS, 32'h15, "late done");
    bus(1'b1, ast_pkg::ADDR_INTERVAL, 32'h0);
    rdc(ast_pkg::ADDR_FLAGS, 32'h1, "masked");
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'hF);
  endtask : t_timer

  // External trigger: no start while the line stays low, one start on its rise.
  task automatic t_ext();
    int n0;
    bus(1'b1, ast_pkg::ADDR_INTERVAL, 32'h10);
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h7);
    wait_st();
    pulse_done();
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'h1);
    rdc(ast_pkg::ADDR_FLAGS, 32'h0, "ready clear");
    n0 = nst;
    repeat (20) @(negedge clk);
    chk("no trigger", n0, nst);
    @(posedge clk);
    ext <= 1'b1;
    repeat (4) @(negedge clk);
    chk("ext start", n0 + 1, nst);
    pulse_done();
    rdc(ast_pkg::ADDR_FLAGS, 32'h11, "ext ready");
    chk("ext irq", 32'h1, {31'h0, irq});
    @(posedge clk);
    ext <= 1'b0;
    bus(1'b1, ast_pkg::ADDR_CONTROL, 32'h0);
    bus(1'b1, ast_pkg::ADDR_FLAGS, 32'hF);
  endtask : t_ext

  // Reset, then the scenarios in turn.
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_iram();
    t_cont();
    t_timer();
    t_ext();
    conclude();
  end
endmodule : ast_status_timer_bench
